// ==== rtl/flash_write_erase_guard.sv ====
// Flash write/erase guard: key lock, routing, self-timing, stall and array
`timescale 1ns/1ps
module flash_write_erase_guard #(
  parameter int ADDR_W = 16,            // Flash address width
  parameter int DEPTH = 1024,           // Flash bytes modelled
  parameter int TIMER_W = 16            // Operation timer width
) (
  input wire logic clock,               // System clock, 250 MHz
  input wire logic arst_n,              // System reset, active low
  input wire logic porReset,            // Power-on reset indication pulse
  input flash_guard_pkg::mem_write_s coreWrite, // Core data-space write
  input flash_guard_pkg::mem_write_s debugWrite, // Debug port flash write
  input wire logic keyWrite,            // Write to flash key register
  input wire logic [7:0] keyData,       // Key byte
  input wire logic writeEnable,         // Program store write enable
  input wire logic eraseEnable,         // Program store erase enable
  input wire logic timingEnable,        // Flash write timing enable
  input wire logic monitorHighSet,      // Software copies high trim
  input wire logic [ADDR_W-1:0] readAddr, // Flash read address
  output logic [7:0] readData,          // Flash read data, registered
  output logic ramWrite,                // Core write routed to data RAM
  output logic coreStall,               // Instruction execution stalled
  output logic flashBusy,               // Operation in progress
  output logic lockedOut,               // Core flash writes disabled till reset
  output logic unlocked,                // Key pair accepted
  output logic monitorHigh              // Monitor at high threshold
);

  localparam logic [TIMER_W-1:0] WRITE_LEN = TIMER_W'(flash_guard_pkg::WRITE_CYCLES);
  localparam logic [TIMER_W-1:0] ERASE_LEN = TIMER_W'(flash_guard_pkg::ERASE_CYCLES);
  localparam int AW = $clog2(DEPTH);

  logic [7:0] mem [DEPTH];
  flash_guard_pkg::flash_op_s op_r;
  flash_guard_pkg::flash_op_s op_nxt;
  logic [7:0] readData_r;
  logic monitorHigh_r;
  logic [AW-1:0] erasePtr_r;
  logic erasing_r;
  logic coreFlash;
  logic reachable;
  logic coreAttempt;
  logic coreStart;
  logic debugStart;
  logic start;
  logic opDone;
  logic timerBusy;
  logic [TIMER_W-1:0] opLen;
  logic [AW-1:0] wordIdx;
  logic [AW-1:0] pageBase;
  logic debugOp_r;
  logic debugOp_nxt;
  logic erasing_nxt;
  logic [AW-1:0] erasePtr_nxt;
  logic eraseHit;
  logic [AW-1:0] eraseAddr;
  logic progHit;
  logic coreOpDone;
  logic monitorHigh_nxt;

  // Page base address of any address
  function automatic logic [AW-1:0] page_of(input logic [ADDR_W-1:0] a);
    page_of = AW'(a) & ~AW'(flash_guard_pkg::PAGE_BYTES - 1);
  endfunction

  // Routing: with write enable set, core writes go to flash, not RAM
  assign coreFlash = coreWrite.valid && writeEnable;
  assign ramWrite = coreWrite.valid && !writeEnable;
  // Short form moves cannot reach flash above the limit
  assign reachable = !coreWrite.shortForm ||
      coreWrite.addr <= flash_guard_pkg::SHORT_FORM_LIMIT;
  assign coreAttempt = coreFlash && reachable && timingEnable && !timerBusy;
  assign coreStart = coreAttempt && unlocked;
  // Debug path needs no key, so a blank device stays programmable
  assign debugStart = debugWrite.valid && !timerBusy && !coreAttempt;
  assign start = coreStart || debugStart;

  // Latch the operation: erase only with both enables on the core path
  always_comb begin
    op_nxt = op_r;
    if (coreStart) begin
      op_nxt.erase = eraseEnable;
      op_nxt.addr = coreWrite.addr;
      op_nxt.data = coreWrite.data;
    end else if (debugStart) begin
      op_nxt.erase = 1'b0;
      op_nxt.addr = debugWrite.addr;
      op_nxt.data = debugWrite.data;
    end
  end

  assign opLen = (coreStart && eraseEnable) ? ERASE_LEN : WRITE_LEN;
  assign flashBusy = timerBusy;
  // Stall covers the start cycle and the whole timed operation
  assign coreStall = timerBusy || start;
  assign wordIdx = AW'(op_r.addr);
  assign pageBase = page_of(op_r.addr);
  assign readData = readData_r;
  assign monitorHigh = monitorHigh_r;

  // Array strobes: an erase walks the page, a program lands at the end
  assign eraseHit = erasing_r && erasePtr_r < AW'(flash_guard_pkg::PAGE_BYTES);
  assign eraseAddr = pageBase | erasePtr_r;
  assign progHit = opDone && !op_r.erase;
  // Debug operations leave the key lock as they found it
  assign coreOpDone = opDone && !debugOp_r;
  // Operation bookkeeping
  assign debugOp_nxt = start ? debugStart : debugOp_r;
  assign erasing_nxt = coreStart ? eraseEnable : (opDone ? 1'b0 : erasing_r);
  assign erasePtr_nxt = coreStart ? '0 : erasePtr_r + AW'(erasing_r);
  // Power-on reset wins over a trim copy in the same cycle
  assign monitorHigh_nxt = porReset ? flash_guard_pkg::MONITOR_HIGH_RESET :
      (monitorHighSet ? 1'b1 : monitorHigh_r);

  flash_key_lock flash_key_lock_inst (
    .clock(clock),
    .arst_n(arst_n),
    .keyWrite(keyWrite),
    .keyData(keyData),
    .opAttempt(coreAttempt),
    .opDone(coreOpDone),
    .unlocked(unlocked),
    .lockedOut(lockedOut)
  );

  flash_op_timer #(
    .WIDTH(TIMER_W)
  ) flash_op_timer_inst (
    .clock(clock),
    .arst_n(arst_n),
    .start(start),
    .cycles(opLen),
    .busy(timerBusy),
    .done(opDone)
  );

  // Remembers which path started the operation; debug ops leave the key alone
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      op_r <= '0;
      debugOp_r <= 1'b0;
    end else begin
      op_r <= op_nxt;
      debugOp_r <= debugOp_nxt;
    end
  end

  // Erase walks the page one byte per cycle while the timer runs
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      erasing_r <= 1'b0;
      erasePtr_r <= '0;
    end else begin
      erasing_r <= erasing_nxt;
      erasePtr_r <= erasePtr_nxt;
    end
  end

  // Array: programming ANDs in the new byte; erase restores ones
  always_ff @(posedge clock) begin
    if (eraseHit) begin
      mem[eraseAddr] <= flash_guard_pkg::ERASED_BYTE;
    end else if (progHit) begin
      mem[wordIdx] <= mem[wordIdx] & op_r.data;
    end
  end

  // Registered read port
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      readData_r <= '0;
    end else begin
      readData_r <= mem[AW'(readAddr)];
    end
  end

  // Monitor threshold: power-on reset forces the low setting
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      monitorHigh_r <= flash_guard_pkg::MONITOR_HIGH_RESET;
    end else begin
      monitorHigh_r <= monitorHigh_nxt;
    end
  end

  // Stall holds while the timer runs
  property p_stall;
    @(posedge clock) disable iff (!arst_n) timerBusy |-> coreStall;
  endproperty
  a_stall: assert property (p_stall) else $error("core not stalled");

  // Short form above the limit never starts an operation
  property p_short;
    @(posedge clock) disable iff (!arst_n)
      (coreWrite.valid && coreWrite.shortForm && coreWrite.addr > 16'h00FF) |-> !coreStart;
  endproperty
  a_short: assert property (p_short) else $error("short form reached flash");

  // Routing is exclusive
  property p_route;
    @(posedge clock) disable iff (!arst_n) coreWrite.valid |-> (ramWrite != coreFlash);
  endproperty
  a_route: assert property (p_route) else $error("write routed wrongly");

  // Power-on reset drops the threshold next cycle
  property p_por;
    @(posedge clock) disable iff (!arst_n) porReset |=> !monitorHigh_r;
  endproperty
  a_por: assert property (p_por) else $error("por left high threshold");

  // Write stalls the core the next cycle, then a done pulse follows within 20 cycles
  property p_write_done;
    @(posedge clock) disable iff (!arst_n)
      (coreStart && !eraseEnable) |=> coreStall ##[0:20] opDone;
  endproperty
  a_write_done: assert property (p_write_done) else $error("write not self-timed");

  // Locked-out device never starts a core operation
  property p_locked;
    @(posedge clock) disable iff (!arst_n) lockedOut |-> !coreStart;
  endproperty
  a_locked: assert property (p_locked) else $error("op while locked out");

  // The start cycle already stalls the core
  property p_start_stalls;
    @(posedge clock) disable iff (!arst_n) start |-> coreStall;
  endproperty
  a_start_stalls: assert property (p_start_stalls) else $error("start without stall");

  // Requests during a running operation are ignored
  property p_busy_refuses;
    @(posedge clock) disable iff (!arst_n) timerBusy |-> !start;
  endproperty
  a_busy_refuses: assert property (p_busy_refuses) else $error("start while busy");

  // A start is followed by a running timer
  property p_start_busy;
    @(posedge clock) disable iff (!arst_n) start |=> flashBusy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("timer not running");

  // One byte per operation: no back-to-back starts
  property p_one_op;
    @(posedge clock) disable iff (!arst_n) start |=> !start;
  endproperty
  a_one_op: assert property (p_one_op) else $error("two starts in a row");

  // With write enable clear the core write goes to RAM only
  property p_ram_route;
    @(posedge clock) disable iff (!arst_n)
      (coreWrite.valid && !writeEnable) |-> (ramWrite && !coreStart);
  endproperty
  a_ram_route: assert property (p_ram_route) else $error("RAM write reached flash");

  // A finished core operation closes the lock
  property p_core_relock;
    @(posedge clock) disable iff (!arst_n) coreOpDone |=> !unlocked;
  endproperty
  a_core_relock: assert property (p_core_relock) else $error("lock open after op");

  // Debug operations program only and are marked as such
  property p_debug_keyless;
    @(posedge clock) disable iff (!arst_n) debugStart |=> (debugOp_r && !op_r.erase);
  endproperty
  a_debug_keyless: assert property (p_debug_keyless) else $error("debug op wrong");

  // Erase time must cover every byte of the page
  property p_erase_span;
    @(posedge clock) disable iff (!arst_n)
      (coreStart && eraseEnable) |-> (opLen >= TIMER_W'(flash_guard_pkg::PAGE_BYTES));
  endproperty
  a_erase_span: assert property (p_erase_span) else $error("erase too short");

  // The page walk stops with the operation
  property p_erase_end;
    @(posedge clock) disable iff (!arst_n) opDone |=> !erasing_r;
  endproperty
  a_erase_end: assert property (p_erase_end) else $error("erase ran past op");

  // Only an open lock lets a core operation start
  property p_write_unlocked;
    @(posedge clock) disable iff (!arst_n) coreStart |-> unlocked;
  endproperty
  a_write_unlocked: assert property (p_write_unlocked) else $error("op without key");

  // Power-on reset beats a simultaneous trim copy
  property p_por_wins;
    @(posedge clock) disable iff (!arst_n) (porReset && monitorHighSet) |=> !monitorHigh;
  endproperty
  a_por_wins: assert property (p_por_wins) else $error("trim copy beat por");

endmodule

// ==== rtl/flash_guard_pkg.sv ====
// Package: constants, types and port groups for the flash write/erase guard
package flash_guard_pkg;

  // Key codes that must reach the flash key register, in this order
  localparam logic [7:0] KEY_FIRST = 8'hA5;
  localparam logic [7:0] KEY_SECOND = 8'hF1;

  // Erased flash content
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // Highest flash address reachable with the 8-bit data-space move form
  localparam logic [15:0] SHORT_FORM_LIMIT = 16'h00FF;

  // Page geometry: 512-byte pages
  localparam int PAGE_BYTES = 512;
  localparam int PAGE_OFFSET_BITS = 9;

  // Register page values used by the threshold copy sequence
  localparam logic [7:0] PAGE_SEL_MONITOR = 8'h01;
  localparam logic [7:0] PAGE_SEL_DEFAULT = 8'h00;

  // Self-timed operation lengths, in their own unit, and derived cycles at 250 MHz
  localparam int CLOCK_MHZ = 250;
  localparam int WRITE_TIME_NS = 40;
  // Erase clears one byte per cycle, so it must last at least a page of cycles
  localparam int ERASE_TIME_NS = 2048;
  localparam int WRITE_CYCLES = (WRITE_TIME_NS * CLOCK_MHZ + 999) / 1000;
  localparam int ERASE_CYCLES = (ERASE_TIME_NS * CLOCK_MHZ + 999) / 1000;

  // Reset values of control state
  localparam logic MONITOR_HIGH_RESET = 1'b0;

  // Key checker states
  typedef enum logic [1:0] {
    KEY_WAIT_FIRST,
    KEY_WAIT_SECOND,
    KEY_OPEN
  } key_state_e;

  // Flash operation request toward the array
  typedef struct packed {
    logic erase;
    logic [15:0] addr;
    logic [7:0] data;
  } flash_op_s;

  // Data-space write from the core or the debug port
  typedef struct packed {
    logic valid;
    logic shortForm;
    logic [15:0] addr;
    logic [7:0] data;
  } mem_write_s;

endpackage

// ==== rtl/flash_key_lock.sv ====
// Lock-and-key checker with sticky lockout
`timescale 1ns/1ps
module flash_key_lock (
  input wire logic clock,              // System clock
  input wire logic arst_n,             // System reset, active low
  input wire logic keyWrite,           // Write strobe to the flash key register
  input wire logic [7:0] keyData,      // Byte written to the flash key register
  input wire logic opAttempt,          // Flash write or erase attempted
  input wire logic opDone,             // Flash operation finished
  output logic unlocked,               // Correct key pair held
  output logic lockedOut               // Core flash operations disabled until reset
);

  flash_guard_pkg::key_state_e keyState_r;
  flash_guard_pkg::key_state_e keyState_nxt;
  logic lockedOut_r;
  logic lockedOut_nxt;
  logic badKey;
  logic badAttempt;

  // A key write in the open state, or a wrong byte, is a sequence error
  assign badKey = keyWrite && (
    (keyState_r == flash_guard_pkg::KEY_WAIT_FIRST && keyData != flash_guard_pkg::KEY_FIRST) ||
    (keyState_r == flash_guard_pkg::KEY_WAIT_SECOND && keyData != flash_guard_pkg::KEY_SECOND) ||
    (keyState_r == flash_guard_pkg::KEY_OPEN));
  assign badAttempt = opAttempt && keyState_r != flash_guard_pkg::KEY_OPEN;
  assign lockedOut_nxt = lockedOut_r | badKey | badAttempt;
  assign unlocked = keyState_r == flash_guard_pkg::KEY_OPEN && !lockedOut_r;
  assign lockedOut = lockedOut_r;

  // Next key state; no timeout exists between the two key writes
  always_comb begin
    keyState_nxt = keyState_r;
    unique case (keyState_r)
      flash_guard_pkg::KEY_WAIT_FIRST: begin
        if (keyWrite && keyData == flash_guard_pkg::KEY_FIRST) begin
          keyState_nxt = flash_guard_pkg::KEY_WAIT_SECOND;
        end
      end
      flash_guard_pkg::KEY_WAIT_SECOND: begin
        if (keyWrite) begin
          keyState_nxt = (keyData == flash_guard_pkg::KEY_SECOND) ?
              flash_guard_pkg::KEY_OPEN : flash_guard_pkg::KEY_WAIT_FIRST;
        end
      end
      flash_guard_pkg::KEY_OPEN: begin
        // Relock on a finished operation or a stray key write
        if (opDone || keyWrite) begin
          keyState_nxt = flash_guard_pkg::KEY_WAIT_FIRST;
        end
      end
      default: keyState_nxt = flash_guard_pkg::KEY_WAIT_FIRST;
    endcase
  end

  // State registers; lockout only clears on reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      keyState_r <= flash_guard_pkg::KEY_WAIT_FIRST;
      lockedOut_r <= 1'b0;
    end else begin
      keyState_r <= keyState_nxt;
      lockedOut_r <= lockedOut_nxt;
    end
  end

  // Lockout once set never drops without reset
  property p_lock_sticky;
    @(posedge clock) disable iff (!arst_n) lockedOut_r |=> lockedOut_r;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lockout dropped");

  // A wrong first byte locks out on the next edge
  property p_bad_key;
    @(posedge clock) disable iff (!arst_n)
      (keyWrite && keyState_r == flash_guard_pkg::KEY_WAIT_FIRST &&
       keyData != flash_guard_pkg::KEY_FIRST) |=> lockedOut_r;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("wrong key not locked out");

  // Attempt while locked sets lockout
  property p_early_attempt;
    @(posedge clock) disable iff (!arst_n)
      (opAttempt && keyState_r != flash_guard_pkg::KEY_OPEN) |=> lockedOut_r;
  endproperty
  a_early_attempt: assert property (p_early_attempt) else $error("early op no lockout");

  // Correct pair opens the lock
  property p_pair_opens;
    @(posedge clock) disable iff (!arst_n)
      (keyWrite && keyData == flash_guard_pkg::KEY_FIRST &&
       keyState_r == flash_guard_pkg::KEY_WAIT_FIRST) ##1
      (keyWrite && keyData == flash_guard_pkg::KEY_SECOND) |=>
      keyState_r == flash_guard_pkg::KEY_OPEN;
  endproperty
  a_pair_opens: assert property (p_pair_opens) else $error("key pair did not open");

  // Finishing an operation relocks
  property p_relock;
    @(posedge clock) disable iff (!arst_n) opDone |=> keyState_r != flash_guard_pkg::KEY_OPEN;
  endproperty
  a_relock: assert property (p_relock) else $error("lock not reset after op");

endmodule

// ==== rtl/flash_op_timer.sv ====
// Self-timed countdown for one flash write or erase
`timescale 1ns/1ps
module flash_op_timer #(
  parameter int WIDTH = 16                // Counter width
) (
  input wire logic clock,                 // System clock
  input wire logic arst_n,                // System reset, active low
  input wire logic start,                 // Start pulse
  input wire logic [WIDTH-1:0] cycles,    // Length of the operation in cycles
  output logic busy,                      // Operation in progress
  output logic done                       // One-cycle pulse at the end
);

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;

  // Load on start, count down to zero; done when reaching the last cycle
  assign busy = count_r != '0;
  assign done = count_r == WIDTH'(1);
  assign count_nxt = start ? cycles : (busy ? count_r - WIDTH'(1) : count_r);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  // A started operation lasts exactly the loaded number of cycles
  property p_length;
    @(posedge clock) disable iff (!arst_n)
      (start && cycles != '0) |=> (busy && count_r == $past(cycles));
  endproperty
  a_length: assert property (p_length) else $error("op length wrong");

endmodule

// ==== dv/core_model.sv ====
// Core-side model: key writes, data-space writes and control bits
`timescale 1ns/1ps
module core_model (
  input wire logic clock, // System clock
  input wire logic coreStall, // Stall from the guard
  input wire logic ramWrite, // RAM routing seen
  output flash_guard_pkg::mem_write_s coreWrite, // Data-space write
  output logic keyWrite, // Key register strobe
  output logic [7:0] keyData, // Key byte
  output logic writeEnable, // Program store write enable
  output logic eraseEnable, // Program store erase enable
  output logic timingEnable, // Write timing enable
  output logic monitorHighSet // Trim copy pulse
);
  // Idle values from time zero; timing enable is set before any operation
  initial begin
    coreWrite = '0;
    keyWrite = 1'b0;
    keyData = 8'h00;
    writeEnable = 1'b1;
    eraseEnable = 1'b0;
    timingEnable = 1'b1;
    monitorHighSet = 1'b0;
  end
  // One key byte; a gap cycle follows so two strobes never merge
  task automatic key(input logic [7:0] b);
    @(posedge clock);
    keyWrite <= 1'b1;
    keyData <= b;
    @(posedge clock);
    keyWrite <= 1'b0;
    keyData <= ~b; // Stale byte must not look valid
  endtask
  // One byte write or page erase, valid for one cycle
  task automatic wr(input logic e, input logic sf, input logic [15:0] a,
      input logic [7:0] d, output logic st, output logic rw);
    @(posedge clock);
    eraseEnable <= e;
    coreWrite <= {1'b1, sf, a, d};
    #1;
    st = coreStall;
    rw = ramWrite;
    @(posedge clock);
    coreWrite <= {1'b0, sf, ~a, ~d};
  endtask
  // Routing of data-space writes
  task automatic cfg(input logic we, input logic te);
    @(posedge clock);
    writeEnable <= we;
    timingEnable <= te;
  endtask
  // Threshold copy, done with the monitor kept on
  task automatic mon();
    @(posedge clock);
    monitorHighSet <= 1'b1;
    @(posedge clock);
    monitorHighSet <= 1'b0;
  endtask
endmodule

// ==== dv/test_flash_write_erase_guard.sv ====
// Self-checking bench for the flash write/erase guard
`timescale 1ns/1ps
module test_flash_write_erase_guard;
  typedef struct packed {
    logic e;
    logic sf;
    logic [15:0] a;
    logic [7:0] d;
    logic [15:0] ra;
    logic [7:0] x;
  } row_s;
  logic clock;
  logic arst_n = 1'b0;
  logic porReset = 1'b0;
  flash_guard_pkg::mem_write_s debugWrite = '0;
  flash_guard_pkg::mem_write_s coreWrite;
  logic [15:0] readAddr = 16'h0000;
  logic [7:0] readData;
  logic [7:0] keyData;
  logic keyWrite, writeEnable, eraseEnable, timingEnable, monitorHighSet;
  logic ramWrite, coreStall, flashBusy, lockedOut, unlocked, monitorHigh;
  logic st, rw;
  int badCount = 0;
  int testsRun = 0;
  // Erase, rewrite (bits only clear), short form, second page, debug, key gap
  row_s rows [9] = '{
    '{1'b1, 1'b0, 16'h0010, 8'h00, 16'h0003, 8'hFF},
    '{1'b0, 1'b0, 16'h0003, 8'h3C, 16'h0003, 8'h3C},
    '{1'b0, 1'b0, 16'h0003, 8'hF0, 16'h0003, 8'h30},
    '{1'b0, 1'b1, 16'h0005, 8'h81, 16'h0005, 8'h81},
    '{1'b1, 1'b0, 16'h0250, 8'h00, 16'h0201, 8'hFF},
    '{1'b0, 1'b0, 16'h0201, 8'h5A, 16'h0201, 8'h5A},
    '{1'b1, 1'b0, 16'h0040, 8'h00, 16'h0003, 8'hFF},
    '{1'b0, 1'b0, 16'h0006, 8'h77, 16'h0006, 8'h77},
    '{1'b0, 1'b0, 16'h0003, 8'h0F, 16'h0003, 8'h0F}};
  logic [15:0] bad [3] = '{16'hA512, 16'hF1A5, 16'hA5A5};

  flash_write_erase_guard flash_write_erase_guard_inst (.clock(clock), .arst_n(arst_n),
    .porReset(porReset), .coreWrite(coreWrite), .debugWrite(debugWrite),
    .keyWrite(keyWrite), .keyData(keyData), .writeEnable(writeEnable),
    .eraseEnable(eraseEnable), .timingEnable(timingEnable), .monitorHighSet(monitorHighSet),
    .readAddr(readAddr), .readData(readData), .ramWrite(ramWrite), .coreStall(coreStall),
    .flashBusy(flashBusy), .lockedOut(lockedOut), .unlocked(unlocked),
    .monitorHigh(monitorHigh));
  core_model core_model_inst (.clock(clock), .coreStall(coreStall), .ramWrite(ramWrite),
    .coreWrite(coreWrite), .keyWrite(keyWrite), .keyData(keyData),
    .writeEnable(writeEnable), .eraseEnable(eraseEnable), .timingEnable(timingEnable),
    .monitorHighSet(monitorHighSet));

  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic doReset();
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    #1;
  endtask
  // Counts busy cycles; the core must stay stalled all along
  task automatic waitOp(input int len);
    int n;
    logic hold;
    n = 0;
    hold = 1'b1;
    #1;
    while (flashBusy === 1'b1 && n < 2000) begin
      hold = hold & coreStall;
      n++;
      @(posedge clock);
      #1;
    end
    chk("busyCycles", 16'(n), 16'(len));
    chk("stallHeld", {15'h0, hold}, 16'h0001);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] x);
    @(posedge clock);
    readAddr <= a;
    repeat (2) @(posedge clock);
    #1;
    chk("readData", {8'h00, readData}, {8'h00, x});
  endtask
  task automatic unlock(input logic x);
    core_model_inst.key(flash_guard_pkg::KEY_FIRST);
    core_model_inst.key(flash_guard_pkg::KEY_SECOND);
    #1;
    chk("unlocked", {15'h0, unlocked}, {15'h0, x});
  endtask
  // Debug writes need no key; core writes are stalled and relock afterwards
  task automatic doOp(input row_s r, input logic dbg);
    if (dbg) begin
      @(posedge clock);
      debugWrite <= {1'b1, 1'b0, r.a, r.d};
      @(posedge clock);
      debugWrite <= {1'b0, 1'b0, ~r.a, ~r.d};
    end else begin
      core_model_inst.wr(r.e, r.sf, r.a, r.d, st, rw);
      chk("coreStall", {15'h0, st}, 16'h0001);
    end
    waitOp(r.e ? flash_guard_pkg::ERASE_CYCLES : flash_guard_pkg::WRITE_CYCLES);
    chk("relocked", {15'h0, unlocked}, 16'h0000);
    rd(r.ra, r.x);
  endtask

  // Main sequence
  initial begin
    doReset();
    chk("resetOuts", {10'h0, ramWrite, lockedOut, unlocked, flashBusy, coreStall,
      monitorHigh}, 16'h0000);
    done("reset");
    for (int i = 0; i < 8; i++) begin
      if (i < 7) begin
        unlock(1'b1);
      end
      doOp(rows[i], i == 7);
    end
    rd(16'h01FF, 8'hFF);
    done("table");
    core_model_inst.key(flash_guard_pkg::KEY_FIRST);
    repeat (50) @(posedge clock);
    core_model_inst.key(flash_guard_pkg::KEY_SECOND);
    #1;
    chk("unlocked", {15'h0, unlocked}, 16'h0001);
    doOp(rows[8], 1'b0);
    done("keyGap");
    core_model_inst.cfg(1'b0, 1'b1);
    core_model_inst.wr(1'b0, 1'b0, 16'h0007, 8'h00, st, rw);
    chk("ramWrite", {15'h0, rw}, 16'h0001);
    waitOp(0);
    chk("lockedOut", {15'h0, lockedOut}, 16'h0000);
    rd(16'h0007, 8'hFF);
    core_model_inst.cfg(1'b1, 1'b1);
    done("ramRoute");
    unlock(1'b1);
    core_model_inst.wr(1'b0, 1'b1, 16'h0100, 8'h00, st, rw);
    waitOp(0);
    core_model_inst.cfg(1'b1, 1'b0);
    core_model_inst.wr(1'b0, 1'b0, 16'h0100, 8'h00, st, rw);
    waitOp(0);
    core_model_inst.cfg(1'b1, 1'b1);
    chk("unlocked", {15'h0, unlocked}, 16'h0001);
    rd(16'h0100, 8'hFF);
    doReset();
    done("shortForm");
    core_model_inst.wr(1'b0, 1'b0, 16'h0008, 8'h00, st, rw);
    waitOp(0);
    chk("lockedOut", {15'h0, lockedOut}, 16'h0001);
    unlock(1'b0);
    doReset();
    chk("lockedOut", {15'h0, lockedOut}, 16'h0000);
    done("early");
    for (int i = 0; i < 3; i++) begin
      core_model_inst.key(bad[i][15:8]);
      core_model_inst.key(bad[i][7:0]);
      #1;
      chk("lockedOut", {15'h0, lockedOut}, 16'h0001);
      unlock(1'b0);
      doReset();
    end
    done("badKeys");
    core_model_inst.mon();
    #1;
    chk("monitorHigh", {15'h0, monitorHigh}, 16'h0001);
    @(posedge clock);
    porReset <= 1'b1;
    @(posedge clock);
    porReset <= 1'b0;
    @(posedge clock);
    #1;
    chk("monitorHigh", {15'h0, monitorHigh}, 16'h0000);
    done("monitor");
    give_verdict();
  end
  // Watchdog: the whole run needs a few thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    badCount++;
    give_verdict();
  end
endmodule
